/* bench/quad_wiper_serial_slave_tb.sv */
/* Bench: wiper table, then nonvolatile, protection, mismatch, abandon.
 Assumes a pull-up on the data wire. */
`timescale 1ns/1ps
`default_nettype none
module quad_wiper_serial_slave_tb
    import qws_pkg::*;
;
typedef struct packed {logic [1:0] pot; logic [7:0] val;} row_t;
logic       core_clk = 1'b0;
logic       rst_b = 1'b0;
logic       wp_b = 1'b1;
logic [3:0] straps = 4'h6;
logic [7:0] idb = 8'ha6;
logic [7:0] q;
logic [1:0] ab;
logic       scl, sda_m, sda_out, sda_oe, nv_busy;
logic [N_POTS-1:0][N_TAPS-1:0] tap_sel;
logic [N_POTS-1:0][BYTE_W-1:0] wiper_pos;
wire logic  sda_w = sda_m & ~sda_oe;
int         failures = 0;
int         n_tests = 0;
int         cyc = 0;
row_t       rows [4] = '{'{2'h0, 8'h00}, '{2'h1, 8'hff}, '{2'h2, 8'h5a}, '{2'h3, 8'h81}};
quad_wiper_serial_slave #(.NV_WRITE_CYCLES(400)) quad_wiper_serial_slave_inst (
    .core_clk(core_clk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out),
    .sda_oe(sda_oe), .address_strap_pins(straps), .write_protect_b(wp_b),
    .tap_sel(tap_sel), .wiper_pos(wiper_pos), .nv_busy(nv_busy));
qws_master qws_master_inst (.core_clk(core_clk), .scl(scl), .sda_m(sda_m), .sda_w(sda_w));
always #12.5 core_clk = ~core_clk;
////////////////////////////////////////////////////////////////////////////////
task automatic test_done();
    if (failures == 0 && n_tests > 0)
        $display("verification passed");
    else
        $display("verification failed");
    $finish;
endtask
task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
        failures++;
        $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
endtask
// Id, then nb further bytes, then stop; acks packed id-instr-data
task automatic cmd(input logic [7:0] ins, input logic [7:0] d, input int nb,
                   input logic [2:0] ea);
    logic [2:0] a;
    a = 3'h0;
    qws_master_inst.frame(1'b1);
    qws_master_inst.xfer(idb, q, a[2]);
    if (nb > 0) qws_master_inst.xfer(ins, q, a[1]);
    if (nb > 1) qws_master_inst.xfer(d, q, a[0]);
    qws_master_inst.frame(1'b0);
    chk({5'h0, a}, {5'h0, ea});
endtask
always @(posedge core_clk)
begin
    cyc++;
    if (cyc == 30000)
    begin
        failures++;
        $display("MISMATCH %0t timeout", $time);
        test_done();
    end
end
////////////////////////////////////////////////////////////////////////////////
initial
begin
    repeat (5) @(negedge core_clk);
    rst_b = 1'b1;
    chk({sda_oe, nv_busy, tap_sel[2][0], wiper_pos[3][4:0]}, 8'h20);
    qws_master_inst.w(4);
    foreach (rows[i])
    begin
        cmd({OP_WRITE_WIPER, 2'h0, rows[i].pot}, rows[i].val, 2, 3'h7);
        chk(wiper_pos[rows[i].pot], rows[i].val);
        chk({7'h0, tap_sel[rows[i].pot][rows[i].val]}, 8'h1);
        cmd({OP_READ_WIPER, 2'h0, rows[i].pot}, 8'hff, 2, 3'h6);
        chk(q, rows[i].val);
    end
    cmd({OP_WRITE_DR, 2'h2, 2'h1}, 8'h3c, 2, 3'h7);
    chk({7'h0, nv_busy}, 8'h1);
    cmd(8'h00, 8'h00, 0, 3'h0);
    for (int k = 0; k < 500 && nv_busy; k++)
        @(negedge core_clk);
    cmd(8'h00, 8'h00, 0, 3'h4);
    qws_master_inst.gap = 4;
    cmd({OP_READ_DR, 2'h2, 2'h1}, 8'hff, 2, 3'h6);
    chk(q, 8'h3c);
    qws_master_inst.gap = 0;
    cmd({OP_DR_TO_WIPER, 2'h2, 2'h1}, 8'h00, 1, 3'h6);
    chk(wiper_pos[1], 8'h3c);
    wp_b = 1'b0;
    cmd({OP_WRITE_DR, 2'h2, 2'h1}, 8'h99, 2, 3'h7);
    chk({7'h0, nv_busy}, 8'h0);
    wp_b = 1'b1;
    cmd({OP_READ_DR, 2'h2, 2'h1}, 8'hff, 2, 3'h6);
    chk(q, 8'h3c);
    idb = 8'ha9;
    cmd({OP_WRITE_WIPER, 2'h0, 2'h0}, 8'h77, 2, 3'h0);
    idb = 8'h36;
    cmd({OP_WRITE_WIPER, 2'h0, 2'h0}, 8'h77, 2, 3'h0);
    idb = 8'ha6;
    chk(wiper_pos[0], 8'h00);
    cmd(8'h20, 8'h00, 1, 3'h4);
    qws_master_inst.frame(1'b1);
    qws_master_inst.xfer(idb, q, ab[1]);
    qws_master_inst.xfer({OP_WRITE_WIPER, 2'h0, 2'h3}, q, ab[0]);
    chk({6'h0, ab}, 8'h03);
    cmd(8'h00, 8'h00, 0, 3'h4);
    chk(wiper_pos[3], 8'h81);
    // Wiper saved into a data register, then read back after the busy time
    cmd({OP_WIPER_TO_DR, 2'h3, 2'h3}, 8'h00, 1, 3'h6);
    chk({7'h0, nv_busy}, 8'h1);
    for (int k = 0; k < 500 && nv_busy; k++)
        @(negedge core_clk);
    cmd({OP_READ_DR, 2'h3, 2'h3}, 8'hff, 2, 3'h6);
    chk(q, 8'h81);
    // Global recall ignores the pot field
    cmd({OP_GLB_DR_TO_WIPER, 2'h2, 2'h0}, 8'h00, 1, 3'h6);
    chk(wiper_pos[2], 8'h00);
    chk(wiper_pos[1], 8'h3c);
    wp_b = 1'b0;
    cmd({OP_GLB_WIPER_TO_DR, 2'h1, 2'h0}, 8'h00, 1, 3'h6);
    chk({7'h0, nv_busy}, 8'h0);
    test_done();
end
endmodule // quad_wiper_serial_slave_tb
bind quad_wiper_serial_slave qws_assertions #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) qws_assertions_inst (
    .core_clk(core_clk), .rst_b(rst_b), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .write_protect_b(write_protect_b), .nv_busy(nv_busy),
    .tap_sel(tap_sel), .wiper_pos(wiper_pos));
`default_nettype wire

/* bench/qws_assertions.sv */
/* Checker on the serial slave top ports.
 Assumes link pins move away from the core clock edge. */
`timescale 1ns/1ps
`default_nettype none
module qws_assertions
    import qws_pkg::*;
#(parameter int NV_WRITE_CYCLES = 50)
(
    // Clock and reset
    input wire logic       core_clk,
    input wire logic       rst_b,
    // Link and protection
    input wire logic       scl_in,
    input wire logic       sda_in,
    input wire logic       sda_out,
    input wire logic       sda_oe,
    input wire logic       write_protect_b,
    input wire logic       nv_busy,
    // Potentiometer side
    input wire logic [N_POTS-1:0][N_TAPS-1:0] tap_sel,
    input wire logic [N_POTS-1:0][BYTE_W-1:0] wiper_pos
);
default clocking @(posedge core_clk); endclocking
default disable iff (!rst_b);
////////////////////////////////////////////////////////////////////////////////
logic [17:0] busy_q;
logic        frame_q;
always_ff @(posedge core_clk or negedge rst_b)
    if (!rst_b)
        busy_q <= 18'h0;
    else
        busy_q <= nv_busy ? busy_q + 18'h1 : 18'h0;
// Pins from the bench are quiet at the edge, so sampling them is safe
always_ff @(posedge core_clk or negedge rst_b)
    if (!rst_b)
        frame_q <= 1'b0;
    else if (scl_in && $past(scl_in) && $changed(sda_in))
        frame_q <= !sda_in;
sequence s_busy_end;
    $fell(nv_busy);
endsequence
////////////////////////////////////////////////////////////////////////////////
AST_TAP_ONEHOT: assert property ($onehot(tap_sel[0]) && $onehot(tap_sel[1])
    && $onehot(tap_sel[2]) && $onehot(tap_sel[3])) else $error("tap not one-hot");
for (genvar p = 0; p < N_POTS; p++)
begin : g_pot
    AST_TAP_DECODE: assert property (tap_sel[p] == (TAP_RST << $past(wiper_pos[p])))
        else $error("tap off wiper");
end
AST_OE_SCL_LOW: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data moved, clock high");
AST_OPEN_DRAIN: assert property (sda_out == 1'b0)
    else $error("data driven high");
AST_BUSY_LEN: assert property (s_busy_end |-> busy_q == 18'(NV_WRITE_CYCLES))
    else $error("busy length");
AST_WP_BLOCK: assert property (!write_protect_b && !$past(write_protect_b, 4) |-> !$rose(nv_busy))
    else $error("protected write ran");
AST_BUSY_NACK: assert property (nv_busy |-> !$rose(sda_oe))
    else $error("ack while busy");
AST_FRAME_ONLY: assert property (sda_oe |-> frame_q)
    else $error("drive outside frame");
endmodule // qws_assertions
`default_nettype wire

/* bench/qws_master.sv */
/* Two-wire master model; sda_m high releases the wire.
 Assumes the bench resolves the wire with a pull-up. */
`timescale 1ns/1ps
`default_nettype none
module qws_master
(
    // Clock
    input  wire logic core_clk,
    // Link
    output var logic  scl,
    output var logic  sda_m,
    input  wire logic sda_w
);
int gap = 0;
initial
begin
    scl = 1'b1;
    sda_m = 1'b1;
end
task automatic w(input int n);
    repeat (n) @(negedge core_clk);
endtask
// Data moves only with clock low; gap makes a slow master
task automatic bitx(input logic b, output logic r);
    w(2 + gap);
    sda_m = b;
    w(2);
    scl = 1'b1;
    w(3);
    r = sda_w;
    w(1);
    scl = 1'b0;
endtask
// Data flips with clock high: start falls stop rises
task automatic frame(input logic open);
    w(2);
    sda_m = open;
    w(2);
    scl = 1'b1;
    w(4);
    sda_m = !open;
    w(4);
    scl = !open;
    w(8);
endtask
task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
        bitx(d[i], r);
        q[i] = r;
    end
    bitx(1'b1, r);
    ack = !r;
endtask
endmodule // qws_master
`default_nettype wire

/* hw/cmd_fifo.sv */
/*
 Command queue: valid/ready FIFO of WIDTH bits by DEPTH entries.
 Assumes DEPTH is a power of two; one clock, asynchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module cmd_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
)
(
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic rst_b,
    // Queue ports
    cmd_fifo_if.store q
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_ptr_q;
    logic [AW-1:0]    rd_ptr_q;
    logic [AW:0]      count_q;
    logic             push;
    logic             pop;

    assign push        = q.in_valid && q.in_ready;
    assign pop         = q.out_valid && q.out_ready;
    assign q.in_ready  = (count_q != (AW+1)'(DEPTH));
    assign q.out_valid = (count_q != '0);
    assign q.out_data  = mem_q[rd_ptr_q];

    // Storage has no reset; contents are only read behind out_valid
    always_ff @(posedge core_clk)
    begin
        if (push)
            mem_q[wr_ptr_q] <= q.in_data;
    end

    // Pointers wrap naturally because depth is a power of two
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_q <= wr_ptr_q + 1'b1;
            if (pop)
                rd_ptr_q <= rd_ptr_q + 1'b1;
            case ({push, pop})
                2'b10:   count_q <= count_q + 1'b1;
                2'b01:   count_q <= count_q - 1'b1;
                default: count_q <= count_q;
            endcase
        end
    end

endmodule // cmd_fifo
`default_nettype wire

/* hw/cmd_fifo_if.sv */
/*
 Carrier between the link front end and its command queue.
 Assumes both ends run on the same core clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface cmd_fifo_if #(parameter int WIDTH = 16);
    logic             in_valid;
    logic             in_ready;
    logic [WIDTH-1:0] in_data;
    logic             out_valid;
    logic             out_ready;
    logic [WIDTH-1:0] out_data;

    modport store  (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
    modport client (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface // cmd_fifo_if
`default_nettype wire

/* hw/quad_wiper_serial_slave.sv */
/*
 Two-wire slave front end of a quad digital potentiometer: start/stop
 detection, identification check, instruction decode, one-byte reads and
 writes, queued command execution, nonvolatile write timing and one-hot
 tap selection for four wipers.
 Assumes the link pins are asynchronous to core_clk and that the open-drain
 data wire is resolved outside from sda_oe (low driven while sda_oe is high).
*/
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Write-protect low refuses every nonvolatile register write
// - Each 8-bit wiper selects one of 256 taps
// - Tap selects of one pot are always one-hot
// - Data changes only while clock is low
// - Commands open with start: data falls, clock high
// - Ignore all traffic until a start is seen
// - Ninth clock: receiver pulls data low to acknowledge
// - Acknowledge matching identification byte, then instruction byte
// - Acknowledge a data byte following the instruction
// - Nonvolatile write cycle starts at the closing stop
// - No address acknowledge while nonvolatile write busy
// - First byte high nibble is the device type
// - Low nibble must equal the address strap pins
// - Only the addressed device executes the instruction
// - Instruction: opcode, register select, pot select fields
// - Sample on clock rise, shift out after fall
// - Straps give the low four address bits
// - Nonvolatile register change completes within 10 ms
module quad_wiper_serial_slave
    import qws_pkg::*;
#(
    parameter int NV_WRITE_CYCLES = NV_WRITE_CYCLES_DFLT
)
(
    // Clock and reset
    input  wire logic                              core_clk,
    input  wire logic                              rst_b,
    // Two-wire link
    input  wire logic                              scl_in,
    input  wire logic                              sda_in,
    output logic                                   sda_out,
    output logic                                   sda_oe,
    // Straps and protection
    input  wire logic [3:0]                        address_strap_pins,
    input  wire logic                              write_protect_b,
    // Potentiometer side
    output logic [N_POTS-1:0][N_TAPS-1:0]          tap_sel,
    output logic [N_POTS-1:0][BYTE_W-1:0]          wiper_pos,
    output logic                                   nv_busy
);

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations

    logic [6:0]        pin_meta_q;
    logic [6:0]        pin_sync_q;
    logic              scl_s;
    logic              sda_s;
    logic              wp_s;
    logic [3:0]        strap_s;
    logic              scl_prev_q;
    logic              sda_prev_q;
    logic              scl_rise;
    logic              scl_fall;
    logic              start_seen;
    logic              stop_seen;

    link_state_t       state_q;
    link_state_t       next_after_byte;
    link_state_t       next_after_ack;
    logic [2:0]        bit_cnt_q;
    logic [7:0]        shift_q;
    logic [7:0]        rx_byte;
    logic [7:0]        tx_q;
    logic              ack_phase_q;
    logic              sda_oe_q;

    logic [7:0]        instr_q;
    logic [7:0]        data_q;
    logic              cmd_ready_q;
    logic              cmd_done;
    logic [3:0]        ins_op;
    logic [1:0]        ins_reg;
    logic [1:0]        ins_pot;
    logic              id_match;
    logic              accept_id;
    logic [7:0]        rd_val;

    logic [7:0]        x_ins;
    logic [7:0]        x_data;
    logic [3:0]        x_op;
    logic [1:0]        x_reg;
    logic [1:0]        x_pot;
    logic              exec_go;
    logic              nv_start;
    logic [NV_CNT_W-1:0] nv_cnt_q;
    logic              nv_busy_q;

    logic [7:0]        wiper_q [N_POTS];
    logic [7:0]        dr_q    [N_POTS][N_REGS];
    logic [N_TAPS-1:0] tap_q   [N_POTS];

    cmd_fifo_if #(.WIDTH(CMD_W)) cmd_q ();

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; only the second stage is looked at

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pin_meta_q <= PIN_SYNC_RST;
            pin_sync_q <= PIN_SYNC_RST;
        end
        else
        begin
            pin_meta_q <= {scl_in, sda_in, write_protect_b, address_strap_pins};
            pin_sync_q <= pin_meta_q;
        end
    end

    assign scl_s   = pin_sync_q[6];
    assign sda_s   = pin_sync_q[5];
    assign wp_s    = pin_sync_q[4];
    assign strap_s = pin_sync_q[3:0];

    // Previous sample, for edges and start/stop
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end
        else
        begin
            scl_prev_q <= scl_s;
            sda_prev_q <= sda_s;
        end
    end

    // Both lines pass the same synchroniser, so their relative order holds
    assign scl_rise   = scl_s && !scl_prev_q;
    assign scl_fall   = !scl_s && scl_prev_q;
    assign start_seen = scl_s && scl_prev_q && sda_prev_q && !sda_s;
    assign stop_seen  = scl_s && scl_prev_q && !sda_prev_q && sda_s;

    ////////////////////////////////////////////////////////////////////////////////
    // Byte decode

    assign rx_byte  = {shift_q[6:0], sda_s};
    assign id_match = (rx_byte[ID_TYPE_LSB +: 4] == DEVICE_TYPE_ID) &&
                      (rx_byte[ID_ADDR_LSB +: 4] == strap_s);
    // A full queue refuses the address just like a busy write does
    assign accept_id = id_match && !nv_busy_q && cmd_q.in_ready;

    assign ins_op  = instr_q[INS_OP_LSB  +: 4];
    assign ins_reg = instr_q[INS_REG_LSB +: 2];
    assign ins_pot = instr_q[INS_POT_LSB +: 2];

    assign rd_val = (ins_op == OP_READ_WIPER) ? wiper_q[ins_pot] : dr_q[ins_pot][ins_reg];

    always_comb
    begin
        case (state_q)
            ST_ID:    next_after_byte = accept_id ? ST_ID_ACK : ST_IDLE;
            ST_INSTR: next_after_byte = op_known(rx_byte[INS_OP_LSB +: 4]) ? ST_INSTR_ACK : ST_DONE;
            ST_WDATA: next_after_byte = ST_WDATA_ACK;
            default:  next_after_byte = ST_IDLE;
        endcase
    end

    always_comb
    begin
        case (state_q)
            ST_ID_ACK:    next_after_ack = ST_INSTR;
            ST_INSTR_ACK:
            begin
                if (op_is_read(ins_op))
                    next_after_ack = ST_RDATA;
                else if (op_needs_data(ins_op))
                    next_after_ack = ST_WDATA;
                else
                    next_after_ack = ST_DONE;
            end
            default:      next_after_ack = ST_DONE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Link state machine; data line only moves on a clock fall

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_q     <= ST_IDLE;
            bit_cnt_q   <= '0;
            shift_q     <= '0;
            tx_q        <= '0;
            ack_phase_q <= 1'b0;
            sda_oe_q    <= 1'b0;
        end
        else if (start_seen || stop_seen)
        begin
            state_q     <= start_seen ? ST_ID : ST_IDLE;
            bit_cnt_q   <= '0;
            ack_phase_q <= 1'b0;
            sda_oe_q    <= 1'b0;
        end
        else
        begin
            case (state_q)
                ST_ID, ST_INSTR, ST_WDATA:
                begin
                    if (scl_rise)
                    begin
                        shift_q   <= rx_byte;
                        bit_cnt_q <= bit_cnt_q + 3'h1;
                        if (bit_cnt_q == LAST_BIT)
                            state_q <= next_after_byte;
                    end
                end
                ST_ID_ACK, ST_INSTR_ACK, ST_WDATA_ACK:
                begin
                    if (scl_fall && !ack_phase_q)
                    begin
                        sda_oe_q    <= 1'b1;
                        ack_phase_q <= 1'b1;
                    end
                    else if (scl_fall)
                    begin
                        ack_phase_q <= 1'b0;
                        state_q     <= next_after_ack;
                        tx_q        <= rd_val;
                        sda_oe_q    <= (next_after_ack == ST_RDATA) && !rd_val[7];
                    end
                end
                ST_RDATA:
                begin
                    if (scl_rise)
                    begin
                        bit_cnt_q <= bit_cnt_q + 3'h1;
                        if (bit_cnt_q == LAST_BIT)
                            state_q <= ST_MACK;
                    end
                    else if (scl_fall)
                    begin
                        tx_q     <= {tx_q[6:0], 1'b0};
                        sda_oe_q <= !tx_q[6];
                    end
                end
                ST_MACK:
                begin
                    // Release for the master's answer; one byte per read
                    if (scl_fall)
                    begin
                        sda_oe_q    <= 1'b0;
                        ack_phase_q <= !ack_phase_q;
                        if (ack_phase_q)
                            state_q <= ST_DONE;
                    end
                end
                default:
                begin
                    sda_oe_q <= 1'b0;
                end
            endcase
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe  = sda_oe_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Command capture; executes only after the closing stop

    assign cmd_done = scl_fall && ack_phase_q &&
                      ((state_q == ST_WDATA_ACK) ||
                       ((state_q == ST_INSTR_ACK) && !op_is_read(ins_op) &&
                        !op_needs_data(ins_op)));

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            instr_q <= '0;
            data_q  <= '0;
        end
        else if (scl_rise && (bit_cnt_q == LAST_BIT) && !start_seen && !stop_seen)
        begin
            if (state_q == ST_INSTR)
                instr_q <= rx_byte;
            if (state_q == ST_WDATA)
                data_q <= rx_byte;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            cmd_ready_q <= 1'b0;
        else if (start_seen || stop_seen)
            cmd_ready_q <= 1'b0;
        else if (cmd_done)
            cmd_ready_q <= 1'b1;
    end

    // Room was checked when the address was acknowledged
    assign cmd_q.in_valid = stop_seen && cmd_ready_q;
    assign cmd_q.in_data  = {instr_q, data_q};

    cmd_fifo #(
        .WIDTH (CMD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_cmd_fifo (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .q        (cmd_q.store)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Executor; the queue stalls while a nonvolatile write runs

    assign x_ins  = cmd_q.out_data[CMD_INS_LSB  +: 8];
    assign x_data = cmd_q.out_data[CMD_DATA_LSB +: 8];
    assign x_op   = x_ins[INS_OP_LSB  +: 4];
    assign x_reg  = x_ins[INS_REG_LSB +: 2];
    assign x_pot  = x_ins[INS_POT_LSB +: 2];

    assign cmd_q.out_ready = !nv_busy_q;
    assign exec_go         = cmd_q.out_valid && !nv_busy_q;
    // Protected writes are dropped silently, with no busy period
    assign nv_start        = exec_go && op_is_nv(x_op) && wp_s;

    // Busy for exactly NV_WRITE_CYCLES core clocks, inside the 10 ms limit
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            nv_cnt_q  <= '0;
            nv_busy_q <= 1'b0;
        end
        else if (nv_start)
        begin
            nv_cnt_q  <= NV_CNT_W'(NV_WRITE_CYCLES - 1);
            nv_busy_q <= 1'b1;
        end
        else if (nv_cnt_q != '0)
        begin
            nv_cnt_q <= nv_cnt_q - 1'b1;
        end
        else
        begin
            nv_busy_q <= 1'b0;
        end
    end

    assign nv_busy = nv_busy_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Per-pot registers and tap decode

    for (genvar p = 0; p < N_POTS; p++)
    begin : g_pot
        logic hit;

        assign hit = op_is_global(x_op) || (x_pot == 2'(p));

        always_ff @(posedge core_clk or negedge rst_b)
        begin
            if (!rst_b)
                wiper_q[p] <= WIPER_RST;
            else if (exec_go && hit)
            begin
                case (x_op)
                    OP_WRITE_WIPER:                     wiper_q[p] <= x_data;
                    OP_DR_TO_WIPER, OP_GLB_DR_TO_WIPER: wiper_q[p] <= dr_q[p][x_reg];
                    default:                            wiper_q[p] <= wiper_q[p];
                endcase
            end
        end

        always_ff @(posedge core_clk or negedge rst_b)
        begin
            if (!rst_b)
                dr_q[p] <= '{default: DR_RST};
            else if (nv_start && hit)
                dr_q[p][x_reg] <= (x_op == OP_WRITE_DR) ? x_data : wiper_q[p];
        end

        // A shifted single one can never light two taps
        always_ff @(posedge core_clk or negedge rst_b)
        begin
            if (!rst_b)
                tap_q[p] <= TAP_RST;
            else
                tap_q[p] <= N_TAPS'(1) << wiper_q[p];
        end

        assign tap_sel[p]   = tap_q[p];
        assign wiper_pos[p] = wiper_q[p];
    end

endmodule // quad_wiper_serial_slave
`default_nettype wire

/* hw/qws_pkg.sv */
/*
 Package for the quad wiper serial slave: sizes, byte field positions,
 opcodes, reset values, timing counts and the link state type.
 Assumes a 40 MHz core clock and a slave-only two-wire link.
*/
package qws_pkg;

    localparam int N_POTS = 4;
    localparam int N_REGS = 4;
    localparam int N_TAPS = 256;
    localparam int BYTE_W = 8;
    localparam int CMD_W  = 16;
    localparam int FIFO_DEPTH = 8;

    // Device-type nibble of the identification byte; value is arbitrary
    localparam logic [3:0] DEVICE_TYPE_ID = 4'ha;

    // Identification byte: type nibble high, strap address low
    localparam int ID_TYPE_LSB = 4;
    localparam int ID_ADDR_LSB = 0;
    // Instruction byte: opcode, register select, pot select
    localparam int INS_OP_LSB  = 4;
    localparam int INS_REG_LSB = 2;
    localparam int INS_POT_LSB = 0;
    // Queued command word: instruction byte over data byte
    localparam int CMD_INS_LSB  = 8;
    localparam int CMD_DATA_LSB = 0;

    localparam logic [3:0] OP_GLB_DR_TO_WIPER = 4'h1;
    localparam logic [3:0] OP_GLB_WIPER_TO_DR = 4'h8;
    localparam logic [3:0] OP_READ_WIPER      = 4'h9;
    localparam logic [3:0] OP_WRITE_WIPER     = 4'ha;
    localparam logic [3:0] OP_READ_DR         = 4'hb;
    localparam logic [3:0] OP_WRITE_DR        = 4'hc;
    localparam logic [3:0] OP_DR_TO_WIPER     = 4'hd;
    localparam logic [3:0] OP_WIPER_TO_DR     = 4'he;

    localparam logic [2:0] LAST_BIT     = 3'h7;
    localparam logic [6:0] PIN_SYNC_RST = 7'h7f;
    localparam logic [7:0] WIPER_RST    = 8'h00;
    localparam logic [7:0] DR_RST       = 8'h00;
    localparam logic [N_TAPS-1:0] TAP_RST = 256'h1;

    localparam int CORE_CLK_HZ       = 40_000_000;
    localparam int NV_WRITE_TIME_US  = 5000;
    localparam int NV_WRITE_MAX_US   = 10000;
    localparam int NV_WRITE_CYCLES_DFLT = NV_WRITE_TIME_US * (CORE_CLK_HZ / 1_000_000);
    localparam int NV_CNT_W          = 18;

    typedef enum logic [3:0] {
        ST_IDLE      = 4'h0,
        ST_ID        = 4'h1,
        ST_ID_ACK    = 4'h2,
        ST_INSTR     = 4'h3,
        ST_INSTR_ACK = 4'h4,
        ST_WDATA     = 4'h5,
        ST_WDATA_ACK = 4'h6,
        ST_RDATA     = 4'h7,
        ST_MACK      = 4'h8,
        ST_DONE      = 4'h9
    } link_state_t;

    function automatic logic op_known(input logic [3:0] op);
        return op inside {OP_GLB_DR_TO_WIPER, OP_GLB_WIPER_TO_DR, OP_READ_WIPER, OP_WRITE_WIPER,
                          OP_READ_DR, OP_WRITE_DR, OP_DR_TO_WIPER, OP_WIPER_TO_DR};
    endfunction

    function automatic logic op_is_read(input logic [3:0] op);
        return op inside {OP_READ_WIPER, OP_READ_DR};
    endfunction

    function automatic logic op_needs_data(input logic [3:0] op);
        return op inside {OP_WRITE_WIPER, OP_WRITE_DR};
    endfunction

    function automatic logic op_is_nv(input logic [3:0] op);
        return op inside {OP_WRITE_DR, OP_WIPER_TO_DR, OP_GLB_WIPER_TO_DR};
    endfunction

    function automatic logic op_is_global(input logic [3:0] op);
        return op inside {OP_GLB_DR_TO_WIPER, OP_GLB_WIPER_TO_DR};
    endfunction

endpackage
